// ### core/timer8_pkg.sv
/*
 Shared constants and types of the 8-bit timer with phase-correct PWM:
 I/O offsets, control field positions, mode and action encodings, prescale masks.
 Assumes it is compiled before every file of the timer.
*/
package timer8_pkg;

  localparam logic [5:0] ADDR_COMPARE = 6'h23;
  localparam logic [5:0] ADDR_COUNTER = 6'h24;
  localparam logic [5:0] ADDR_CONTROL = 6'h25;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;

  localparam int BIT_FORCE     = 7;
  localparam int BIT_WGM_LOW   = 6;
  localparam int BIT_COM_HI    = 5;
  localparam int BIT_COM_LO    = 4;
  localparam int BIT_WGM_HIGH  = 3;
  localparam int BIT_CS_HI     = 2;
  localparam int BIT_CS_LO     = 0;

  typedef enum logic [1:0] {WGM_NORMAL, WGM_PHASE, WGM_CTC, WGM_FAST} wgm_t;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_A   = 3'h6;
  localparam logic [2:0] CS_EXT_B   = 3'h7;

  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV64   = 10'h03f;
  localparam logic [9:0] MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  localparam int PC_PERIOD_TICKS = 510;

  function automatic logic is_pwm(wgm_t m);
    return (m == WGM_PHASE) || (m == WGM_FAST);
  endfunction

endpackage

// ### core/tick_prescaler.sv
/*
 Timer tick source: free-running divider of mclk and falling-edge detector
 on the external count pin, selected by the clock select field.
 Assumes the external pin is already synchronous to mclk.
*/
`timescale 1ns/1ps
module tick_prescaler
  import timer8_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] clock_select,
  input  wire logic       external_count_pin,
  output logic            timer_tick
);

  typedef struct packed {
    logic [9:0] div;
    logic       ext_prev;
    logic       tick;
  } pre_state_t;

  pre_state_t s_r;
  pre_state_t s_nxt;

  function automatic logic tick_due(logic [2:0] cs, logic [9:0] div, logic fall);
    case (cs)
      CS_STOP:    return 1'b0;
      CS_DIV1:    return 1'b1;
      CS_DIV8:    return (div & MASK_DIV8) == MASK_DIV8;
      CS_DIV64:   return (div & MASK_DIV64) == MASK_DIV64;
      CS_DIV256:  return (div & MASK_DIV256) == MASK_DIV256;
      CS_DIV1024: return (div & MASK_DIV1024) == MASK_DIV1024;
      default:    return fall;
    endcase
  endfunction

  always_comb begin
    s_nxt          = s_r;
    s_nxt.div      = s_r.div + 10'h001;
    s_nxt.ext_prev = external_count_pin;
    // Shared divider, so a new division starts mid-count
    s_nxt.tick     = tick_due(clock_select, s_r.div,
                              s_r.ext_prev & ~external_count_pin);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign timer_tick = s_r.tick;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_stop_no_tick: assert property (clock_select == CS_STOP |=> !timer_tick)
    else $error("tick seen while clock stopped");
  a_div8_spacing: assert property (
    (clock_select == CS_DIV8) && timer_tick && $stable(clock_select) |=> !timer_tick)
    else $error("divide by 8 ticked twice in a row");
  c_ext_tick: cover property ((clock_select == CS_EXT_A) && timer_tick);

endmodule

// ### core/compare_output_unit.sv
/*
 Waveform generator for the compare output: acts on compare matches,
 forced compares, the phase-correct top turnaround and the fast PWM bottom.
 Assumes the match, top and bottom event inputs are already qualified by the timer tick; the force strobe is not.
*/
`timescale 1ns/1ps
module compare_output_unit
  import timer8_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire wgm_t       mode,
  input  wire logic [1:0] action,
  input  wire logic       match,
  input  wire logic       match_down,
  input  wire logic       top_event,
  input  wire logic       top_hold_high,
  input  wire logic       bottom_event,
  input  wire logic       force_strobe,
  output logic            oc_level
);

  typedef struct packed {
    logic oc;
  } ocu_state_t;

  ocu_state_t s_r;
  ocu_state_t s_nxt;

  function automatic logic plain_next(logic [1:0] com, logic cur);
    case (com)
      COM_TOGGLE: return ~cur;
      COM_CLEAR:  return 1'b0;
      COM_SET:    return 1'b1;
      default:    return cur;
    endcase
  endfunction

  // Level after an up-counting match, or after a down-counting one
  function automatic logic pwm_level(logic [1:0] com, logic up);
    return up ? (com == COM_SET) : (com == COM_CLEAR);
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (!is_pwm(mode)) begin
      if (match || force_strobe) begin
        s_nxt.oc = plain_next(action, s_r.oc);
      end
    end else if ((action == COM_CLEAR) || (action == COM_SET)) begin
      if (match) begin
        s_nxt.oc = pwm_level(action, (mode == WGM_FAST) || !match_down);
      end
      if (top_event) begin
        s_nxt.oc = pwm_level(action, !top_hold_high);
      end
      if (bottom_event) begin
        s_nxt.oc = pwm_level(action, 1'b0);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign oc_level = s_r.oc;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_force_pwm_quiet: assert property (
    is_pwm(mode) && force_strobe && !match && !top_event && !bottom_event
    |=> $stable(oc_level))
    else $error("forced compare changed a PWM output");
  a_force_sets_out: assert property (
    !is_pwm(mode) && force_strobe && (action == COM_SET) |=> oc_level)
    else $error("forced compare did not set the output");
  a_pc_up_clear: assert property (
    (mode == WGM_PHASE) && (action == COM_CLEAR) && match && !match_down |=> !oc_level)
    else $error("up-count match did not clear");
  a_pc_down_set: assert property (
    (mode == WGM_PHASE) && (action == COM_CLEAR) && match && match_down |=> oc_level)
    else $error("down-count match did not set");
  a_top_symmetry: assert property (
    (mode == WGM_PHASE) && (action == COM_CLEAR) && top_event && !top_hold_high
    |=> !oc_level)
    else $error("level at top is not the up-count result");
  a_toggle_match: assert property (
    !is_pwm(mode) && (action == COM_TOGGLE) && match && !force_strobe
    |=> oc_level != $past(oc_level))
    else $error("toggle on match did not toggle");

endmodule

// ### core/timer8_phase_correct_pwm.sv
/*
 8-bit timer/counter with normal, CTC, fast PWM and phase-correct PWM modes,
 three I/O registers (control, counter, compare) and one compare output pin.
 Assumes a single-cycle I/O port synchronous to mclk, flag clears as pulses
 from the flag register outside, and the pin direction bit as a level.
*/
//
// Contract
// - Waveform mode 1 counts zero up to maximum and back down, repeatedly.
// - Non-inverting: up-count match drives low, down-count match drives high.
// - Fixed eight-bit range; counter holds maximum one tick, then reverses.
// - Phase-correct sets the overflow flag whenever the counter reaches zero.
// - Output action 2 gives non-inverted PWM, 3 gives inverted PWM.
// - Compare level reaches the pin only when its direction is output.
// - One phase-correct period lasts 510 timer ticks.
// - Compare zero gives constant low, maximum constant high; inverted opposite.
// - Level held at maximum equals the up-count match result, or the down-count one with compare at maximum.
// - A missed up-count match still yields its output change at the top.
// - Fully synchronous; the timer tick only enables counting, flags and compare output events.
// - Force strobe acts only in non-PWM modes, never in PWM modes.
// - Force strobe applies an immediate match using the current output action.
// - Forced compare sets no flag and never clears the counter.
// - Force bit sits at bit 7, write-only, always reads zero.
// - Mode field bits 3 and 6 pick normal, phase, CTC, fast PWM.
// - Compare update and overflow point depend on mode per the mode table.
// - Clock select: stop, divide 1, 8, 64, 256, 1024, external edges.
// - Writing the counter suppresses the compare match on the next tick.
// - Non-PWM actions: disconnected, toggle, clear, set on match.
// - Compare value is matched continuously; a match sets the compare flag. In PWM modes a match at maximum is ignored and sets no flag.
`timescale 1ns/1ps
module timer8_phase_correct_pwm
  import timer8_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [5:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_we,
  input  wire logic       io_re,
  output logic      [7:0] io_rdata,
  input  wire logic       ovf_flag_clear,
  input  wire logic       cmp_flag_clear,
  input  wire logic       pin_dir_out,
  input  wire logic       external_count_pin,
  output logic            compare_output_pin,
  output logic            compare_pin_oe_b,
  output logic            overflow_flag,
  output logic            compare_flag
);

  typedef struct packed {
    wgm_t       wgm;
    logic [1:0] com;
    logic [2:0] cs;
    logic [7:0] cnt;
    logic [7:0] ocr_wr;
    logic [7:0] ocr_act;
    logic       down;
    logic       block;
    logic       ovf;
    logic       cmp;
    logic       force_p;
    logic [7:0] rdata;
    logic       pin;
    logic       oe_b;
  } timer_state_t;

  timer_state_t s_r;
  timer_state_t s_nxt;

  logic timer_tick;
  logic oc_level;
  logic hit;
  logic at_max;
  logic top_event;
  logic bottom_event;
  logic ctrl_write;

  function automatic logic [7:0] control_image(wgm_t m, logic [1:0] com, logic [2:0] cs);
    logic [1:0] mb;
    mb = m;
    return {1'b0, mb[0], com, mb[1], cs};
  endfunction

  tick_prescaler u_prescaler (
    .mclk               (mclk),
    .rst_b              (rst_b),
    .clock_select       (s_r.cs),
    .external_count_pin (external_count_pin),
    .timer_tick         (timer_tick)
  );

  // Matches at maximum are ignored in PWM; the top or bottom event acts instead
  assign at_max       = s_r.cnt == CNT_MAX;
  assign hit          = timer_tick && !s_r.block && (s_r.cnt == s_r.ocr_act) &&
                        !(is_pwm(s_r.wgm) && at_max);
  assign top_event    = timer_tick && (s_r.wgm == WGM_PHASE) && !s_r.down && at_max;
  assign bottom_event = timer_tick && (s_r.wgm == WGM_FAST) && at_max;
  assign ctrl_write   = io_we && (io_addr == ADDR_CONTROL);

  compare_output_unit u_output (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .mode          (s_r.wgm),
    .action        (s_r.com),
    .match         (hit),
    .match_down    (s_r.down),
    .top_event     (top_event),
    .top_hold_high (s_r.ocr_wr == CNT_MAX),
    .bottom_event  (bottom_event),
    .force_strobe  (s_r.force_p),
    .oc_level      (oc_level)
  );

  always_comb begin
    s_nxt         = s_r;
    s_nxt.force_p = 1'b0;
    // Clears first so a same-cycle set wins
    if (ovf_flag_clear) begin
      s_nxt.ovf = 1'b0;
    end
    if (cmp_flag_clear) begin
      s_nxt.cmp = 1'b0;
    end

    if (timer_tick) begin
      s_nxt.block = 1'b0;
      unique case (s_r.wgm)
        WGM_PHASE: begin
          if (!s_r.down) begin
            if (at_max) begin
              s_nxt.down    = 1'b1;
              s_nxt.cnt     = s_r.cnt - CNT_ONE;
              s_nxt.ocr_act = s_r.ocr_wr;
            end else begin
              s_nxt.cnt = s_r.cnt + CNT_ONE;
            end
          end else if (s_r.cnt == CNT_BOTTOM) begin
            s_nxt.down = 1'b0;
            s_nxt.cnt  = CNT_ONE;
          end else begin
            s_nxt.cnt = s_r.cnt - CNT_ONE;
            if (s_r.cnt == CNT_ONE) begin
              s_nxt.down = 1'b0;
              s_nxt.ovf  = 1'b1;
            end
          end
        end
        WGM_CTC: begin
          s_nxt.down = 1'b0;
          // Forced compare never reaches here, so it cannot clear the count
          if (hit) begin
            s_nxt.cnt = CNT_BOTTOM;
          end else begin
            s_nxt.cnt = s_r.cnt + CNT_ONE;
          end
          if (at_max) begin
            s_nxt.ovf = 1'b1;
          end
        end
        WGM_FAST: begin
          s_nxt.down = 1'b0;
          s_nxt.cnt  = s_r.cnt + CNT_ONE;
          if (at_max) begin
            s_nxt.ovf     = 1'b1;
            s_nxt.ocr_act = s_r.ocr_wr;
          end
        end
        WGM_NORMAL: begin
          s_nxt.down = 1'b0;
          s_nxt.cnt  = s_r.cnt + CNT_ONE;
          if (at_max) begin
            s_nxt.ovf = 1'b1;
          end
        end
      endcase
      if (hit) begin
        s_nxt.cmp = 1'b1;
      end
    end

    if (io_we) begin
      unique case (io_addr)
        ADDR_CONTROL: begin
          s_nxt.wgm     = wgm_t'({io_wdata[BIT_WGM_HIGH], io_wdata[BIT_WGM_LOW]});
          s_nxt.com     = io_wdata[BIT_COM_HI:BIT_COM_LO];
          s_nxt.cs      = io_wdata[BIT_CS_HI:BIT_CS_LO];
          s_nxt.force_p = io_wdata[BIT_FORCE];
        end
        ADDR_COUNTER: begin
          s_nxt.cnt   = io_wdata;
          s_nxt.block = 1'b1;
        end
        ADDR_COMPARE: begin
          s_nxt.ocr_wr = io_wdata;
        end
        default: begin
        end
      endcase
    end

    // Immediate compare update outside the PWM modes
    if (!is_pwm(s_nxt.wgm)) begin
      s_nxt.ocr_act = s_nxt.ocr_wr;
    end

    if (io_re) begin
      unique case (io_addr)
        ADDR_CONTROL: s_nxt.rdata = control_image(s_r.wgm, s_r.com, s_r.cs);
        ADDR_COUNTER: s_nxt.rdata = s_r.cnt;
        ADDR_COMPARE: s_nxt.rdata = s_r.ocr_wr;
        default:      s_nxt.rdata = 8'h00;
      endcase
    end

    // Pin is driven only with an action selected and direction set to output
    s_nxt.oe_b = !(pin_dir_out && (s_r.com != COM_OFF));
    s_nxt.pin  = pin_dir_out && (s_r.com != COM_OFF) && oc_level;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r         <= '0;
      s_r.wgm     <= wgm_t'({CONTROL_RESET[BIT_WGM_HIGH], CONTROL_RESET[BIT_WGM_LOW]});
      s_r.com     <= CONTROL_RESET[BIT_COM_HI:BIT_COM_LO];
      s_r.cs      <= CONTROL_RESET[BIT_CS_HI:BIT_CS_LO];
      s_r.cnt     <= COUNTER_RESET;
      s_r.ocr_wr  <= COMPARE_RESET;
      s_r.ocr_act <= COMPARE_RESET;
      s_r.oe_b    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign io_rdata           = s_r.rdata;
  assign compare_output_pin = s_r.pin;
  assign compare_pin_oe_b   = s_r.oe_b;
  assign overflow_flag      = s_r.ovf;
  assign compare_flag       = s_r.cmp;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pc_top_turn: assert property (
    timer_tick && (s_r.wgm == WGM_PHASE) && !s_r.down && at_max && !io_we
    |=> (s_r.cnt == 8'hfe) && s_r.down)
    else $error("phase-correct count did not turn at maximum");
  a_pc_bottom_ovf: assert property (
    timer_tick && (s_r.wgm == WGM_PHASE) && s_r.down && (s_r.cnt == CNT_ONE) && !io_we
    |=> (s_r.cnt == CNT_BOTTOM) && !s_r.down && overflow_flag)
    else $error("overflow not flagged at bottom");
  a_ovf_at_max: assert property (
    timer_tick && (s_r.wgm == WGM_NORMAL) && at_max && !io_we
    |=> (s_r.cnt == CNT_BOTTOM) && overflow_flag)
    else $error("normal mode did not wrap with overflow");
  a_ctc_wrap: assert property (
    (s_r.wgm == WGM_CTC) && hit && !io_we |=> s_r.cnt == CNT_BOTTOM)
    else $error("CTC did not clear on match");
  a_read_force: assert property (
    io_re && (io_addr == ADDR_CONTROL) |=> !io_rdata[BIT_FORCE])
    else $error("force bit read back as one");
  a_write_blocks: assert property (
    io_we && (io_addr == ADDR_COUNTER) && (io_wdata == s_r.ocr_act) && !is_pwm(s_r.wgm)
    ##1 timer_tick && !io_we && !compare_flag
    |=> !compare_flag)
    else $error("match not suppressed after counter write");
  a_force_no_flag: assert property (
    s_r.force_p && !hit && !compare_flag |=> !compare_flag)
    else $error("forced compare set the compare flag");
  a_pin_released: assert property (
    !pin_dir_out |=> compare_pin_oe_b && !compare_output_pin)
    else $error("pin driven while direction is input");
  a_ovf_set_wins: assert property (
    ovf_flag_clear && timer_tick && (s_r.wgm == WGM_PHASE) && s_r.down &&
    (s_r.cnt == CNT_ONE) && !io_we |=> overflow_flag)
    else $error("overflow lost against a clear");
  // Buffered compare must not move mid-slope, or the pulse loses symmetry
  a_pc_ocr_hold: assert property (
    (s_r.wgm == WGM_PHASE) && !top_event && !io_we |=> $stable(s_r.ocr_act))
    else $error("phase-correct compare changed away from top");
  a_pc_ocr_load: assert property (
    top_event && !io_we |=> s_r.ocr_act == $past(s_r.ocr_wr))
    else $error("compare value not loaded at top");
  a_pc_no_top_ovf: assert property (
    top_event && !overflow_flag && !io_we |=> !overflow_flag)
    else $error("overflow flagged at top in phase-correct mode");
  a_fast_wrap: assert property (
    timer_tick && (s_r.wgm == WGM_FAST) && at_max && !io_we
    |=> (s_r.cnt == CNT_BOTTOM) && overflow_flag)
    else $error("fast PWM did not wrap with overflow");
  a_count_on_tick: assert property (
    !timer_tick && !io_we |=> $stable(s_r.cnt))
    else $error("counter moved without a timer tick");
  a_pin_driven: assert property (
    pin_dir_out && (s_r.com != COM_OFF) |=> !compare_pin_oe_b)
    else $error("pin not driven while direction is output");

  c_pc_turn: cover property (top_event);
  c_pc_ovf: cover property ((s_r.wgm == WGM_PHASE) && $rose(overflow_flag));
  c_forced: cover property (s_r.force_p && !is_pwm(s_r.wgm));
  c_pin_on: cover property (!compare_pin_oe_b && compare_output_pin);

endmodule

// ### tb/pwm_load.sv
/*
 Load on the compare output pin: a pull-down resistor with a timing probe
 that measures the last full period and the last high time in mclk cycles.
 Assumes the pin is released whenever its active-low enable is high.
*/
`timescale 1ns/1ps
module pwm_load (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pin,
  input  wire logic pin_oe_b,
  output logic      level,
  output int        rises,
  output int        period,
  output int        high
);
  int   since_rise;
  logic level_d;

  // Released pin falls to the pull-down instead of keeping its last value
  assign level = pin_oe_b ? 1'b0 : pin;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level_d    <= 1'b0;
      since_rise <= 0;
      rises      <= 0;
      period     <= 0;
      high       <= 0;
    end else begin
      level_d    <= level;
      since_rise <= since_rise + 1;
      if (level && !level_d) begin
        rises      <= rises + 1;
        period     <= since_rise;
        since_rise <= 1;
      end
      if (!level && level_d) begin
        high <= since_rise;
      end
    end
  end
endmodule

// ### tb/testbench.sv
/*
 Self-checking bench of the 8-bit timer: register port, forced compares,
 pin release, phase-correct period, duty, constant levels and overflow spacing.
 Assumes the timer package and the pin load model pwm_load.
*/
`timescale 1ns/1ps
module testbench
  import timer8_pkg::*;
;
  logic       mclk, rst_b, io_we, io_re, ovf_flag_clear, cmp_flag_clear;
  logic       pin_dir_out, level;
  logic       ext_pin = 1'b0;
  logic       compare_output_pin, compare_pin_oe_b, overflow_flag, compare_flag;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, d, e;
  logic [1:0] ext_div = 2'h0;
  int         rises, period, high, cyc, n_mismatch, num_checks, t0, t1, ocr;
  localparam logic [5:0] addrs[4]   = '{ADDR_CONTROL, ADDR_COUNTER, ADDR_COMPARE, 6'h3f};
  localparam logic [7:0] frc[4]     = '{8'hb0, 8'ha0, 8'h90, 8'he0};
  localparam logic       frc_lvl[4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  timer8_phase_correct_pwm timer8_phase_correct_pwm_i (
    .mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata), .ovf_flag_clear(ovf_flag_clear),
    .cmp_flag_clear(cmp_flag_clear), .pin_dir_out(pin_dir_out),
    .external_count_pin(ext_pin), .compare_output_pin(compare_output_pin),
    .compare_pin_oe_b(compare_pin_oe_b), .overflow_flag(overflow_flag),
    .compare_flag(compare_flag));

  pwm_load pwm_load_i (
    .mclk(mclk), .rst_b(rst_b), .pin(compare_output_pin), .pin_oe_b(compare_pin_oe_b),
    .level(level), .rises(rises), .period(period), .high(high));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // External source: one falling edge every four cycles
  always @(negedge mclk) begin
    ext_div <= ext_div + 2'h1;
    if (ext_div[0]) ext_pin <= ~ext_pin;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic note(bit ok, string msg);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk1(logic got, logic exp, string m);
    note(got === exp, $sformatf("%s got %b exp %b", m, got, exp));
  endtask
  task automatic chk8(logic [7:0] got, logic [7:0] exp, string m);
    note(got === exp, $sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic chki(int got, int exp, string m);
    note(got == exp, $sformatf("%s got %0d exp %0d", m, got, exp));
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] v);
    @(negedge mclk);
    io_addr = a;
    io_wdata = v;
    io_we = 1'b1;
    @(negedge mclk);
    io_we = 1'b0;
  endtask
  task automatic rd(logic [5:0] a, output logic [7:0] v);
    @(negedge mclk);
    io_addr = a;
    io_re = 1'b1;
    @(negedge mclk);
    io_re = 1'b0;
    v = io_rdata;
  endtask
  task automatic clr_flags();
    @(negedge mclk);
    {ovf_flag_clear, cmp_flag_clear} = 2'b11;
    @(negedge mclk);
    {ovf_flag_clear, cmp_flag_clear} = 2'b00;
  endtask
  task automatic wait_ovf(output int t);
    for (int i = 0; i < 1100 && overflow_flag !== 1'b1; i++) @(negedge mclk);
    t = cyc;
    if (overflow_flag !== 1'b1) begin
      note(1'b0, "timeout on overflow");
      summarize();
    end
  endtask
  task automatic wait_rises(int n, int bound);
    int r0;
    r0 = rises;
    for (int i = 0; i < bound && rises < r0 + n; i++) @(negedge mclk);
    if (rises < r0 + n) begin
      note(1'b0, "timeout on pin edges");
      summarize();
    end
  endtask

  function automatic logic [7:0] ctl(logic [1:0] act, logic [2:0] cs);
    return {2'b01, act, 1'b0, cs};
  endfunction
  function automatic logic [7:0] mctl(wgm_t m, logic [1:0] act, logic [2:0] cs);
    logic [1:0] mb;
    mb = m;
    return {1'b0, mb[0], act, mb[1], cs};
  endfunction
  function automatic int exp_high(logic [7:0] oc, logic [1:0] act, int n);
    return (act == COM_CLEAR) ? 2 * oc * n : (PC_PERIOD_TICKS - 2 * oc) * n;
  endfunction

  task automatic measure(logic [7:0] oc, logic [1:0] act, logic [2:0] cs, int n);
    wr(ADDR_COMPARE, oc);
    wr(ADDR_CONTROL, ctl(act, cs));
    wait_rises(3, 2200 * n);
    chki(period, PC_PERIOD_TICKS * n, "pwm period");
    chki(high, exp_high(oc, act, n), "pwm high time");
  endtask
  task automatic run_mode(logic [7:0] oc, logic [7:0] cw, int per, int hi);
    wr(ADDR_COMPARE, oc);
    wr(ADDR_CONTROL, cw);
    wait_rises(3, 2200);
    chki(period, per, "mode period");
    chki(high, hi, "mode high time");
  endtask

  initial begin
    {io_addr, io_wdata, io_we, io_re, ovf_flag_clear, cmp_flag_clear} = '0;
    rst_b = 1'b0;
    pin_dir_out = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h82e2));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    chk1(compare_pin_oe_b, 1'b1, "pin after reset");
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      chk8(d, 8'h00, "reset value");
    end
    // Random fields with the clock stopped, so nothing counts yet
    d = 8'($urandom());
    d[2:0] = CS_STOP;
    d[7] = 1'b1;
    wr(ADDR_CONTROL, d);
    rd(ADDR_CONTROL, e);
    chk8(e, {1'b0, d[6:0]}, "control readback");
    wr(ADDR_CONTROL, 8'h00);
    foreach (frc[i]) begin
      wr(ADDR_CONTROL, frc[i]);
      repeat (4) @(negedge mclk);
      chk1(level, frc_lvl[i], "forced level");
    end
    chk1(compare_flag, 1'b0, "flag after force");
    pin_dir_out = 1'b0;
    repeat (3) @(negedge mclk);
    chk1(compare_pin_oe_b, 1'b1, "pin as input");
    pin_dir_out = 1'b1;
    repeat (3) @(negedge mclk);
    chk1(compare_pin_oe_b, 1'b0, "pin as output");
    measure(8'h01, COM_CLEAR, CS_DIV1, 1);
    measure(8'hfe, COM_SET, CS_DIV1, 1);
    clr_flags();
    wait_ovf(t0);
    clr_flags();
    wait_ovf(t1);
    chki(t1 - t0, PC_PERIOD_TICKS, "overflow spacing");
    chk1(compare_flag, 1'b1, "compare flag");
    repeat (6) begin
      ocr = $urandom_range(254, 1);
      measure(8'(ocr), ($urandom_range(1, 0) != 0) ? COM_SET : COM_CLEAR, CS_DIV1, 1);
    end
    measure(8'($urandom_range(200, 20)), COM_CLEAR, CS_DIV8, 8);
    measure(8'h30, COM_SET, CS_EXT_A, 4);
    measure(8'h50, COM_CLEAR, CS_EXT_B, 4);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_COMPARE, k[0] ? CNT_MAX : CNT_BOTTOM);
      wr(ADDR_CONTROL, ctl(k[1] ? COM_SET : COM_CLEAR, CS_DIV1));
      // Two periods let the buffered compare value settle
      repeat (1100) @(negedge mclk);
      t0 = 0;
      repeat (520) begin
        @(negedge mclk);
        t0 += (level === 1'b1);
      end
      chki(t0, (k[0] ^ k[1]) ? 520 : 0, "constant level");
    end
    ocr = $urandom_range(200, 2);
    run_mode(8'(ocr), mctl(WGM_CTC, COM_TOGGLE, CS_DIV1), 2 * (ocr + 1), ocr + 1);
    run_mode(8'(ocr), mctl(WGM_FAST, COM_CLEAR, CS_DIV1), 256, ocr + 1);
    // Counter loaded with the compare value on a running timer
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNTER, CNT_BOTTOM);
    clr_flags();
    wr(ADDR_COMPARE, 8'h40);
    wr(ADDR_CONTROL, mctl(WGM_NORMAL, COM_OFF, CS_DIV1));
    wr(ADDR_COUNTER, 8'h40);
    repeat (8) @(negedge mclk);
    chk1(compare_flag, 1'b0, "match after counter write");
    repeat (260) @(negedge mclk);
    chk1(compare_flag, 1'b1, "match after a full wrap");
    chk1(overflow_flag, 1'b1, "overflow at wrap");
    summarize();
  end
endmodule
